// [shared/trim_map_regs.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef TRIM_MAP_REGS_SVH
`define TRIM_MAP_REGS_SVH
`define ADDR_OFFSET_CH0   7'h0F
`define ADDR_GAIN_CH0     7'h10
`define ADDR_OFFSET_CH1   7'h11
`define ADDR_GAIN_CH1     7'h12
`define ADDR_OFFSET_CH2   7'h13
`define ADDR_GAIN_CH2     7'h14
`define ADDR_KEY_CRC      7'h1F
`define ADDR_TRIM_CTRL    7'h0E
`define KEY_UNLOCK        8'hA5
`define KEY_LSB           16
`define KEY_MSB           23
`define CTRL_OFFSET_BIT   0
`define CTRL_GAIN_BIT     1
`define CTRL_ALERT_BIT    2
`define CRC_PERIOD        4'hE
`define CRC_POLY          16'h8005
`define GAIN_LATENCY      24
`define GAIN_FRAC_BITS    23
`define UNDEF_READ        24'h000000
`endif

// [shared/trim_map_pkg.sv]
// Types shared by the trim and map lock block
package trim_map_pkg;
  typedef logic signed [23:0] sample_t;
  typedef enum logic [1:0] {
    MAP_OPEN   = 2'b00,
    MAP_REF    = 2'b01,
    MAP_WATCH  = 2'b10,
    MAP_ALERT  = 2'b11
  } map_state_t;
endpackage : trim_map_pkg

// [rtl/sample_fifo.sv]
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic             push, pop;
  always_comb begin
    in_ready_o  = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
    out_valid_o = wr_ff != rd_ff;
    push        = in_valid_i && in_ready_o;
    pop         = out_valid_o && out_ready_i;
    nxt_wr      = wr_ff + (AW+1)'(push);
    nxt_rd      = rd_ff + (AW+1)'(pop);
    out_data_o  = mem_ff[rd_ff[AW-1:0]];
  end
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
    end
  end
  // Storage needs no reset; occupancy is guarded by pointers
  always_ff @(posedge sys_clk_i) begin
    if (push) mem_ff[wr_ff[AW-1:0]] <= in_data_i;
  end
endmodule : sample_fifo
`default_nettype wire

// [rtl/channel_trim.sv]
// One channel: offset add, then delayed gain multiply
`timescale 1ns/100ps
`default_nettype none
`include "trim_map_regs.svh"
module channel_trim
  import trim_map_pkg::*;
#(
  parameter int LATENCY = `GAIN_LATENCY
) (
  input  wire logic          sys_clk_i,
  input  wire logic          reset_n_i,
  input  wire logic          valid_i,
  input  wire sample_t       code_i,
  input  wire logic          offset_en_i,
  input  wire logic          gain_en_i,
  input  wire sample_t       offset_i,
  input  wire sample_t       gain_i,
  output logic               valid_o,
  output sample_t            code_o
);
  if (LATENCY < 2) begin : g_bad_latency
    $error("LATENCY must be at least 2");
  end
  logic signed [24:0] summed;
  logic signed [25:0] mult;
  logic signed [50:0] product;
  logic signed [24:0] scaled;
  sample_t            corrected, trimmed;
  logic    [LATENCY-1:0] vpipe_ff, nxt_vpipe;
  sample_t            dpipe_ff [LATENCY];
  sample_t            nxt_dpipe [LATENCY];
  always_comb begin
    summed    = 25'(code_i) + 25'(offset_i);
    corrected = offset_en_i ? sample_t'(summed) : code_i;
    mult      = 26'(gain_i) + (26'sd1 <<< `GAIN_FRAC_BITS);
    product   = 51'(corrected) * 51'(mult);
    scaled    = 25'(product >>> `GAIN_FRAC_BITS);
    // Saturate: 1 + gain can reach almost 2x
    if (scaled > 25'sh7FFFFF) trimmed = 24'sh7FFFFF;
    else if (scaled < -25'sh800000) trimmed = 24'sh800000;
    else trimmed = sample_t'(scaled);
    nxt_vpipe    = {vpipe_ff[LATENCY-2:0], valid_i && gain_en_i};
    nxt_dpipe[0] = trimmed;
    for (int i = 1; i < LATENCY; i++) nxt_dpipe[i] = dpipe_ff[i-1];
  end
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vpipe_ff <= '0;
      for (int i = 0; i < LATENCY; i++) dpipe_ff[i] <= '0;
    end else begin
      vpipe_ff <= nxt_vpipe;
      for (int i = 0; i < LATENCY; i++) dpipe_ff[i] <= nxt_dpipe[i];
    end
  end
  // Gain path is delayed by LATENCY; bypass adds nothing
  always_comb begin
    if (gain_en_i) begin
      valid_o = vpipe_ff[LATENCY-1];
      code_o  = dpipe_ff[LATENCY-1];
    end else begin
      valid_o = valid_i;
      code_o  = corrected;
    end
  end
endmodule : channel_trim
`default_nettype wire

// [rtl/trim_and_map_lock_checksum.sv]
// Per-channel offset and gain trim with register map lock and checksum
// Operation
// - With offset trim on, each channel's signed offset is added to its code.
// - With offset trim off, offsets are ignored but kept.
// - Gain LSB is a multiplier step of two to the minus twenty-three.
// - With gain trim on, the offset-corrected code is multiplied by one plus gain.
// - Gain codes 0x800000 to 0x7FFFFF give a multiplier from zero to under two.
// - With gain trim off, gains are ignored but kept.
// - The write key resets to 0xA5.
// - Key at 0xA5 opens all writes, clears checksum and alert, stops checksum work.
// - Any other key allows writes only to the key register; other reads are undefined.
// - While locked the checksum runs and a mismatch alerts only when enabled.
// - The checksum over the writable map is refreshed every 14 clocks.
// - The checksum field is read only and is zero while unlocked.
// - Offset trim adds no latency.
// - Gain trim delays data and ready by 24 clocks.
// - An enabled alert holds the ready pin low until the key is 0xA5 again.
`timescale 1ns/100ps
`default_nettype none
`include "trim_map_regs.svh"
module trim_and_map_lock_checksum
  import trim_map_pkg::*;
#(
  parameter int CHANNELS   = 3,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 reset_n_i,
  input  wire logic [CHANNELS-1:0]  sample_valid_i,
  input  wire logic [CHANNELS*24-1:0] sample_code_i,
  output logic                      sample_ready_o,
  output logic                      out_valid_o,
  output logic [1:0]                out_channel_o,
  output logic [23:0]               out_code_o,
  input  wire logic                 out_ready_i,
  output logic                      data_ready_pin_n_o,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  input  wire logic [6:0]           reg_addr_i,
  input  wire logic [23:0]          reg_wdata_i,
  output logic [23:0]               reg_rdata_o,
  output logic                      reg_rvalid_o
);
  if (CHANNELS != 3) begin : g_bad_channels
    $error("CHANNELS must be 3 to match the register map");
  end
  logic [23:0]  offset_ff [CHANNELS];
  logic [23:0]  gain_ff   [CHANNELS];
  logic [23:0]  nxt_offset [CHANNELS];
  logic [23:0]  nxt_gain   [CHANNELS];
  logic [7:0]   key_ff, nxt_key;
  logic [2:0]   ctrl_ff, nxt_ctrl;
  logic [15:0]  crc_ff, nxt_crc, ref_ff, nxt_ref, crc_acc_ff, nxt_crc_acc;
  logic [3:0]   tick_ff, nxt_tick;
  map_state_t   state_ff, nxt_state;
  logic         alert_ff, nxt_alert;
  logic [23:0]  rdata_ff, nxt_rdata;
  logic         rvalid_ff, nxt_rvalid;
  logic         unlocked;
  logic [3:0]   msg_idx;
  logic [23:0]  msg_word;
  logic [CHANNELS-1:0] trim_valid;
  sample_t      trim_code [CHANNELS];
  logic         slot_valid_ff, nxt_slot_valid;
  logic [1:0]   slot_ch_ff, nxt_slot_ch;
  sample_t      slot_code_ff, nxt_slot_code;
  logic [CHANNELS-1:0] pend_ff, nxt_pend;
  sample_t      pend_code_ff [CHANNELS];
  sample_t      nxt_pend_code [CHANNELS];
  logic         fifo_in_ready, fifo_out_valid;
  logic [25:0]  fifo_out_data;
  logic         dr_ff, nxt_dr;
  logic         vld_ff, nxt_vld;
  logic [1:0]   och_ff, nxt_och;
  logic [23:0]  ocode_ff, nxt_ocode;

  assign unlocked = key_ff == `KEY_UNLOCK;

  generate
    for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
      channel_trim #(.LATENCY(`GAIN_LATENCY)) u_trim (
        .sys_clk_i   (sys_clk_i),
        .reset_n_i   (reset_n_i),
        .valid_i     (sample_valid_i[c]),
        .code_i      (sample_t'(sample_code_i[c*24 +: 24])),
        .offset_en_i (ctrl_ff[`CTRL_OFFSET_BIT]),
        .gain_en_i   (ctrl_ff[`CTRL_GAIN_BIT]),
        .offset_i    (sample_t'(offset_ff[c])),
        .gain_i      (sample_t'(gain_ff[c])),
        .valid_o     (trim_valid[c]),
        .code_o      (trim_code[c])
      );
    end
  endgenerate

  // Register writes and reads
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      nxt_offset[c] = offset_ff[c];
      nxt_gain[c]   = gain_ff[c];
    end
    nxt_key    = key_ff;
    nxt_ctrl   = ctrl_ff;
    nxt_rvalid = reg_rd_i;
    nxt_rdata  = rdata_ff;
    if (reg_wr_i) begin
      if (reg_addr_i == `ADDR_KEY_CRC) nxt_key = reg_wdata_i[`KEY_MSB:`KEY_LSB];
      else if (unlocked) begin
        case (reg_addr_i)
          `ADDR_OFFSET_CH0: nxt_offset[0] = reg_wdata_i;
          `ADDR_GAIN_CH0:   nxt_gain[0]   = reg_wdata_i;
          `ADDR_OFFSET_CH1: nxt_offset[1] = reg_wdata_i;
          `ADDR_GAIN_CH1:   nxt_gain[1]   = reg_wdata_i;
          `ADDR_OFFSET_CH2: nxt_offset[2] = reg_wdata_i;
          `ADDR_GAIN_CH2:   nxt_gain[2]   = reg_wdata_i;
          `ADDR_TRIM_CTRL:  nxt_ctrl      = reg_wdata_i[2:0];
          default:          nxt_ctrl      = ctrl_ff;
        endcase
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i == `ADDR_KEY_CRC) nxt_rdata = {key_ff, unlocked ? 16'h0000 : crc_ff};
      else if (!unlocked) nxt_rdata = `UNDEF_READ;
      else begin
        case (reg_addr_i)
          `ADDR_OFFSET_CH0: nxt_rdata = offset_ff[0];
          `ADDR_GAIN_CH0:   nxt_rdata = gain_ff[0];
          `ADDR_OFFSET_CH1: nxt_rdata = offset_ff[1];
          `ADDR_GAIN_CH1:   nxt_rdata = gain_ff[1];
          `ADDR_OFFSET_CH2: nxt_rdata = offset_ff[2];
          `ADDR_GAIN_CH2:   nxt_rdata = gain_ff[2];
          `ADDR_TRIM_CTRL:  nxt_rdata = {21'h000000, ctrl_ff};
          default:          nxt_rdata = 24'h000000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int c = 0; c < CHANNELS; c++) begin
        offset_ff[c] <= 24'h000000;
        gain_ff[c]   <= 24'h000000;
      end
      key_ff    <= `KEY_UNLOCK;
      ctrl_ff   <= 3'h0;
      rdata_ff  <= 24'h000000;
      rvalid_ff <= 1'b0;
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        offset_ff[c] <= nxt_offset[c];
        gain_ff[c]   <= nxt_gain[c];
      end
      key_ff    <= nxt_key;
      ctrl_ff   <= nxt_ctrl;
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // Checksum message: seven writable words then zero words, one word per clock, 14 clocks per pass
  always_comb begin
    msg_idx = tick_ff;
    case (msg_idx)
      4'h0:    msg_word = offset_ff[0];
      4'h1:    msg_word = gain_ff[0];
      4'h2:    msg_word = offset_ff[1];
      4'h3:    msg_word = gain_ff[1];
      4'h4:    msg_word = offset_ff[2];
      4'h5:    msg_word = gain_ff[2];
      4'h6:    msg_word = {21'h000000, ctrl_ff};
      default: msg_word = 24'h000000;
    endcase
  end

  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [23:0] word);
    logic [15:0] r;
    r = crc;
    for (int b = 23; b >= 0; b--) begin
      r = (r[15] ^ word[b]) ? ((r << 1) ^ `CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc_step

  always_comb begin
    nxt_tick    = tick_ff;
    nxt_crc_acc = crc_acc_ff;
    nxt_crc     = crc_ff;
    nxt_ref     = ref_ff;
    nxt_state   = state_ff;
    nxt_alert   = alert_ff;
    if (unlocked) begin
      nxt_tick    = 4'h0;
      nxt_crc_acc = 16'h0000;
      nxt_crc     = 16'h0000;
      nxt_alert   = 1'b0;
      nxt_state   = MAP_OPEN;
    end else begin
      nxt_crc_acc = crc_step(crc_acc_ff, msg_word);
      nxt_tick    = tick_ff + 4'h1;
      if (tick_ff == `CRC_PERIOD - 4'h1) begin
        nxt_tick    = 4'h0;
        // Finished sum is taken before the accumulator restarts
        nxt_crc     = nxt_crc_acc;
        nxt_crc_acc = 16'h0000;
        case (state_ff)
          MAP_OPEN, MAP_REF: begin
            nxt_ref   = nxt_crc;
            nxt_state = MAP_WATCH;
          end
          MAP_WATCH: begin
            if (nxt_crc != ref_ff && ctrl_ff[`CTRL_ALERT_BIT]) begin
              nxt_alert = 1'b1;
              nxt_state = MAP_ALERT;
            end
          end
          MAP_ALERT: nxt_alert = 1'b1;
          default:   nxt_state = MAP_OPEN;
        endcase
      end else if (state_ff == MAP_OPEN) nxt_state = MAP_REF;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_ff    <= 4'h0;
      crc_acc_ff <= 16'h0000;
      crc_ff     <= 16'h0000;
      ref_ff     <= 16'h0000;
      state_ff   <= MAP_OPEN;
      alert_ff   <= 1'b0;
    end else begin
      tick_ff    <= nxt_tick;
      crc_acc_ff <= nxt_crc_acc;
      crc_ff     <= nxt_crc;
      ref_ff     <= nxt_ref;
      state_ff   <= nxt_state;
      alert_ff   <= nxt_alert;
    end
  end

  // Merge channels into one stream; a second sample on a busy channel overwrites
  always_comb begin
    nxt_pend      = pend_ff;
    nxt_pend_code = pend_code_ff;
    for (int c = 0; c < CHANNELS; c++) begin
      if (trim_valid[c]) begin
        nxt_pend[c]      = 1'b1;
        nxt_pend_code[c] = trim_code[c];
      end
    end
    nxt_slot_valid = slot_valid_ff && !fifo_in_ready;
    nxt_slot_ch    = slot_ch_ff;
    nxt_slot_code  = slot_code_ff;
    if (!nxt_slot_valid) begin
      for (int c = CHANNELS - 1; c >= 0; c--) begin
        if (pend_ff[c]) begin
          nxt_slot_valid = 1'b1;
          nxt_slot_ch    = 2'(c);
          nxt_slot_code  = pend_code_ff[c];
        end
      end
      if (nxt_slot_valid && !trim_valid[nxt_slot_ch]) nxt_pend[nxt_slot_ch] = 1'b0;
    end
    nxt_dr = |trim_valid;
  end

  sample_fifo #(.WIDTH(26), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (slot_valid_ff),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({slot_ch_ff, slot_code_ff}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (!vld_ff || out_ready_i),
    .out_data_o  (fifo_out_data)
  );

  always_comb begin
    nxt_vld   = vld_ff;
    nxt_och   = och_ff;
    nxt_ocode = ocode_ff;
    if (!vld_ff || out_ready_i) begin
      nxt_vld   = fifo_out_valid;
      nxt_och   = fifo_out_data[25:24];
      nxt_ocode = fifo_out_data[23:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pend_ff       <= '0;
      slot_valid_ff <= 1'b0;
      slot_ch_ff    <= 2'h0;
      slot_code_ff  <= '0;
      dr_ff         <= 1'b0;
      vld_ff        <= 1'b0;
      och_ff        <= 2'h0;
      ocode_ff      <= 24'h000000;
      for (int c = 0; c < CHANNELS; c++) pend_code_ff[c] <= '0;
    end else begin
      pend_ff       <= nxt_pend;
      slot_valid_ff <= nxt_slot_valid;
      slot_ch_ff    <= nxt_slot_ch;
      slot_code_ff  <= nxt_slot_code;
      dr_ff         <= nxt_dr;
      vld_ff        <= nxt_vld;
      och_ff        <= nxt_och;
      ocode_ff      <= nxt_ocode;
      for (int c = 0; c < CHANNELS; c++) pend_code_ff[c] <= nxt_pend_code[c];
    end
  end

  // Pin low on ready pulse or while alert holds
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) data_ready_pin_n_o <= 1'b1;
    else data_ready_pin_n_o <= !(nxt_dr || nxt_alert);
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) sample_ready_o <= 1'b0;
    else sample_ready_o <= !(&pend_ff);
  end

  assign out_valid_o   = vld_ff;
  assign out_channel_o = och_ff;
  assign out_code_o    = ocode_ff;
  assign reg_rdata_o   = rdata_ff;
  assign reg_rvalid_o  = rvalid_ff;
endmodule : trim_and_map_lock_checksum
`default_nettype wire

// [bench/trim_map_asserts.sv]
// Port-level checks for the trim and map lock block
`timescale 1ns/100ps
`default_nettype none
`include "trim_map_regs.svh"
module trim_map_asserts #(
  parameter int CHANNELS   = 3,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic                   sys_clk_i,
  input wire logic                   reset_n_i,
  input wire logic [CHANNELS-1:0]    sample_valid_i,
  input wire logic [CHANNELS*24-1:0] sample_code_i,
  input wire logic                   sample_ready_o,
  input wire logic                   out_valid_o,
  input wire logic [1:0]             out_channel_o,
  input wire logic [23:0]            out_code_o,
  input wire logic                   out_ready_i,
  input wire logic                   data_ready_pin_n_o,
  input wire logic                   reg_wr_i,
  input wire logic                   reg_rd_i,
  input wire logic [6:0]             reg_addr_i,
  input wire logic [23:0]            reg_wdata_i,
  input wire logic [23:0]            reg_rdata_o,
  input wire logic                   reg_rvalid_o
);
  logic [7:0] key_ff;
  logic [7:0] nxt_key;
  logic       gain_ff;
  logic       nxt_gain;
  logic       open_w;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Shadow of what the host wrote; control only lands while open
  always_comb begin
    nxt_key  = key_ff;
    nxt_gain = gain_ff;
    if (reg_wr_i && reg_addr_i == `ADDR_KEY_CRC) nxt_key = reg_wdata_i[`KEY_MSB:`KEY_LSB];
    if (reg_wr_i && open_w && reg_addr_i == `ADDR_TRIM_CTRL) begin
      nxt_gain = reg_wdata_i[`CTRL_GAIN_BIT];
    end
  end
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      key_ff  <= `KEY_UNLOCK;
      gain_ff <= 1'b0;
    end else begin
      key_ff  <= nxt_key;
      gain_ff <= nxt_gain;
    end
  end
  assign open_w = (key_ff == `KEY_UNLOCK);
  sequence s_key_rd;
    reg_rd_i && reg_addr_i == `ADDR_KEY_CRC;
  endsequence
  a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
    else $error("rvalid without read");
  a_key_readback: assert property (s_key_rd |=> reg_rdata_o[23:16] == key_ff)
    else $error("key field wrong");
  a_open_crc_zero: assert property (s_key_rd ##0 (open_w && $past(open_w))
    |=> reg_rdata_o[15:0] == 16'h0000) else $error("checksum not zero while open");
  a_locked_read_blank: assert property (reg_rd_i && !open_w
    && reg_addr_i != `ADDR_KEY_CRC |=> reg_rdata_o == `UNDEF_READ) else $error("locked read leaks");
  a_open_low_limit: assert property (not (open_w && !data_ready_pin_n_o)[*4])
    else $error("ready pin stuck low while open");
  a_pulse_no_gain: assert property (|sample_valid_i && !gain_ff |=> !data_ready_pin_n_o)
    else $error("ready pulse late");
  a_pulse_gain: assert property (|sample_valid_i && gain_ff |-> ##25 !data_ready_pin_n_o)
    else $error("gain ready pulse missing");
  a_out_hold: assert property (out_valid_o && !out_ready_i
    |=> out_valid_o && $stable(out_code_o) && $stable(out_channel_o)) else $error("word dropped");
endmodule : trim_map_asserts
`default_nettype wire

// [bench/trim_map_far_side.sv]
// Sample producer and stalling stream sink at the block's far side
`timescale 1ns/100ps
`default_nettype none
module trim_map_far_side (
  input  wire logic        sys_clk_i,
  input  wire logic        stall_i,
  output logic [2:0]       sample_valid_o,
  output logic [71:0]      sample_code_o,
  output logic             out_ready_o,
  input  wire logic        out_valid_i,
  input  wire logic [1:0]  out_channel_i,
  input  wire logic [23:0] out_code_i
);
  logic [25:0] got_q[$];
  initial begin
    sample_valid_o = 3'h0;
    sample_code_o  = 72'h0;
  end
  assign out_ready_o = !stall_i;
  // Codes inverted once valid drops, so stale data never looks fresh
  task automatic send(input logic [2:0] mask, input logic [71:0] codes);
    sample_valid_o = mask;
    sample_code_o  = codes;
    @(posedge sys_clk_i);
    #2;
    sample_valid_o = 3'h0;
    sample_code_o  = ~codes;
  endtask : send
  always @(posedge sys_clk_i) begin
    if (out_valid_i && out_ready_o) got_q.push_back({out_channel_i, out_code_i});
  end
endmodule : trim_map_far_side
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the trim and map lock block
`timescale 1ns/100ps
`default_nettype none
`include "trim_map_regs.svh"
module testbench
  import trim_map_pkg::*;
;
  logic        sys_clk_i, reset_n_i, sample_ready_o, out_valid_o, out_ready_i;
  logic        data_ready_pin_n_o, reg_wr_i, reg_rd_i, reg_rvalid_o, stall;
  logic [2:0]  sample_valid_i;
  logic [71:0] sample_code_i;
  logic [1:0]  out_channel_o;
  logic [23:0] out_code_o, reg_wdata_i, reg_rdata_o;
  logic [6:0]  reg_addr_i;
  int          n_errors, compares, lat;
  sample_t     offs[3], gns[3], codes[3];
  logic [25:0] w;
  trim_and_map_lock_checksum uut (.sys_clk_i, .reset_n_i, .sample_valid_i, .sample_code_i,
    .sample_ready_o, .out_valid_o, .out_channel_o, .out_code_o, .out_ready_i,
    .data_ready_pin_n_o, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
    .reg_rvalid_o);
  trim_map_far_side far (.sys_clk_i, .stall_i(stall), .sample_valid_o(sample_valid_i),
    .sample_code_o(sample_code_i), .out_ready_o(out_ready_i), .out_valid_i(out_valid_o),
    .out_channel_i(out_channel_o), .out_code_i(out_code_o));
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic finish_test();
    if (n_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task automatic check(input logic [25:0] seen, input logic [25:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #2;
  endtask : tick
  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    reg_wr_i    = 1'b1;
    reg_addr_i  = a;
    reg_wdata_i = d;
    tick(1);
    reg_wr_i = 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [23:0] exp);
    reg_rd_i   = 1'b1;
    reg_addr_i = a;
    tick(1);
    reg_rd_i = 1'b0;
    check({1'b0, reg_rvalid_o, reg_rdata_o}, {2'b01, exp});
    tick(1);
  endtask : rd
  // Wide intermediate so the saturating gain result is exact
  function automatic sample_t trim(input sample_t c, o, g, input bit oe, ge);
    longint v;
    v = oe ? longint'(c) + longint'(o) : longint'(c);
    if (ge) v = (v * (longint'(g) + 64'sd8388608)) >>> 23;
    if (v > 64'sd8388607) v = 64'sd8388607;
    if (v < -64'sd8388608) v = -64'sd8388608;
    return sample_t'(v);
  endfunction : trim
  function automatic logic [15:0] map_crc(input logic [23:0] ctl);
    logic [15:0] r;
    logic [23:0] wd;
    r = 16'h0000;
    for (int i = 0; i < 14; i++) begin
      wd = (i < 6) ? ((i % 2) ? gns[i/2] : offs[i/2]) : ((i == 6) ? ctl : 24'h000000);
      for (int b = 23; b >= 0; b--)
        r = (r[15] ^ wd[b]) ? ({r[14:0], 1'b0} ^ `CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction : map_crc
  task automatic run(input bit oe, input bit ge);
    for (int c = 0; c < 3; c++) begin
      far.send(3'h1 << c, {3{codes[c]}});
      lat = 0;
      while (data_ready_pin_n_o !== 1'b0 && lat < 40) begin
        tick(1);
        lat++;
      end
      check(26'(lat), ge ? 26'd24 : 26'd0);
      for (int i = 0; i < 60 && far.got_q.size() == 0; i++) tick(1);
      w = far.got_q.pop_front();
      check(w, {2'(c), trim(codes[c], offs[c], gns[c], oe, ge)});
    end
  endtask : run
  initial begin
    #100000;
    n_errors++;
    finish_test();
  end
  initial begin
    reset_n_i   = 1'b0;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    reg_addr_i  = 7'h00;
    reg_wdata_i = 24'h000000;
    stall       = 1'b0;
    n_errors    = 0;
    compares    = 0;
    offs  = '{24'sd1000, -24'sd50000, 24'sd7};
    gns   = '{24'h400000, 24'h800000, 24'h7FFFFF};
    codes = '{24'sd12345, 24'sd300000, 24'h600000};
    tick(8);
    reset_n_i = 1'b1;
    rd(`ADDR_KEY_CRC, {`KEY_UNLOCK, 16'h0000});
    for (int c = 0; c < 3; c++) begin
      wr(`ADDR_OFFSET_CH0 + 7'(2*c), offs[c]);
      wr(`ADDR_GAIN_CH0 + 7'(2*c), gns[c]);
      rd(`ADDR_OFFSET_CH0 + 7'(2*c), offs[c]);
      rd(`ADDR_GAIN_CH0 + 7'(2*c), gns[c]);
    end
    for (int m = 0; m < 4; m++) begin
      wr(`ADDR_TRIM_CTRL, 24'(m));
      run(m[0], m[1]);
    end
    wr(`ADDR_TRIM_CTRL, 24'h000004);
    rd(`ADDR_GAIN_CH2, gns[2]);
    // Lock with junk in the checksum bits, which must not stick
    wr(`ADDR_KEY_CRC, 24'h5AFFFF);
    tick(3 * 14);
    rd(`ADDR_KEY_CRC, {8'h5A, map_crc(24'h000004)});
    rd(`ADDR_OFFSET_CH0, `UNDEF_READ);
    wr(`ADDR_OFFSET_CH0, 24'h000055);
    tick(14);
    rd(`ADDR_KEY_CRC, {8'h5A, map_crc(24'h000004)});
    far.send(3'h1, {3{codes[0]}});
    tick(3);
    check({25'h0, data_ready_pin_n_o}, 26'h1);
    wr(`ADDR_KEY_CRC, {`KEY_UNLOCK, 16'h0000});
    rd(`ADDR_OFFSET_CH0, offs[0]);
    rd(`ADDR_KEY_CRC, {`KEY_UNLOCK, 16'h0000});
    wr(`ADDR_TRIM_CTRL, 24'h000000);
    tick(10);
    far.got_q.delete();
    stall = 1'b1;
    for (int r = 0; r < 8; r++) begin
      far.send(3'h7, {24'(3*r+2), 24'(3*r+1), 24'(3*r)});
      tick(6);
    end
    check({25'h0, sample_ready_o}, 26'h0);
    stall = 1'b0;
    for (int i = 0; i < 200 && far.got_q.size() < 16; i++) tick(1);
    check(26'(far.got_q.size() >= 16), 26'h1);
    for (int k = 0; k < 16; k++) check(far.got_q[k], {2'(k % 3), 24'(k)});
    finish_test();
  end
endmodule : testbench
bind trim_and_map_lock_checksum trim_map_asserts #(.CHANNELS(CHANNELS),
  .FIFO_DEPTH(FIFO_DEPTH)) chk (.sys_clk_i, .reset_n_i, .sample_valid_i, .sample_code_i,
  .sample_ready_o, .out_valid_o, .out_channel_o, .out_code_o, .out_ready_i,
  .data_ready_pin_n_o, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
  .reg_rvalid_o);
`default_nettype wire
